// ===== src/bbsr_cfg.svh
/*
  constants for the buck-boost and slew register bank: offsets, fields, resets, timing.
  assumes a 100 MHz core clock and an 8-bit subaddressed register port.
*/
// Summary of operation
// - third buck codes 24h-3Fh decode to 2.050-3.400 V in 50 mV steps.
// - buck-boost control register sits at 0x19 and resets to 0xB2 or strap default.
// - buck-boost writes take effect only once the password is satisfied.
// - any buck-boost write blanks over/undervoltage supervision for 5 ms.
// - bit 7 pulse-skip enable, reset 1; 0 forces fixed frequency.
// - bit 6 reads zero and ignores writes.
// - bits 5-0 voltage code, reset 32h; 25 mV then 50 mV steps.
// - strap-sampled resistor select may change third buck and buck-boost defaults; here the strap default is also 0xB2 and third buck ignores it.
// - slew register sits at 0x1A and resets to 0x6.
// - slew rate governs only first and second buck transitions.
// - slew bits: 7 trigger, 6 bypass, 5-3 read zero, 2-0 rate code.
// - trigger starts stepping toward set-points; device clears it when done.
// - with bypass set, set-point writes start slewed transitions directly.
// - rate codes 0-6 give 160 down to 2.5 us per step; 7 immediate.
`ifndef BBSR_CFG_SVH
`define BBSR_CFG_SVH
`define BBSR_ADDR_BB 8'h19
`define BBSR_ADDR_SLEW 8'h1A
`define BBSR_BB_RESET 8'hB2
`define BBSR_BB_ALT_RESET 8'hB2
`define BBSR_SLEW_RESET 8'h06
`define BBSR_BIT_PSKIP 7
`define BBSR_BIT_TRIG 7
`define BBSR_BIT_BYPASS 6
`define BBSR_CODE_MSB 5
`define BBSR_RATE_MSB 2
`define BBSR_RATE_SLOW_SHIFT 3'h6
`define BBSR_STRAP_FILL 2'h3
`define BBSR_BB_CODE_MASK 8'h3F
`define BBSR_SLEW_RATE_MASK 8'h07
`define BBSR_RATE_IMM 3'h7
`define BBSR_TB3_UPPER 6'h24
`define BBSR_BLANK_MS 5
`define BBSR_CLK_MHZ 100
`define BBSR_BLANK_CYC (`BBSR_BLANK_MS * 1000 * `BBSR_CLK_MHZ)
`define BBSR_STEP_BASE_NS 2500
`define BBSR_STEP_BASE_CYC (`BBSR_STEP_BASE_NS * `BBSR_CLK_MHZ / 1000)
`define BBSR_TB3_BASE_MV 2050
`define BBSR_TB3_STEP_MV 50
`endif

// ===== src/bbsr_pkg.sv
/*
  types for the buck-boost and slew register bank.
  assumes bbsr_cfg.svh holds the numeric constants.
*/
`default_nettype none
package bbsr_pkg;
  typedef enum logic [1:0] {
    BBSR_IDLE = 2'b01,
    BBSR_STEP = 2'b10
  } bbsr_state_t;
endpackage
`default_nettype wire

// ===== src/bbsr_regs.sv
/*
  register bank for the buck-boost control and transition slew registers, with
  supervision blanking and a set-point stepping engine for the first two bucks.
  assumes a register port already decoded from the management bus (one write strobe,
  one address, read data returned a cycle later), a password-ok level from the
  protection logic, and a resistor-select strap pin.
  the strap is caught once its three-flop synchroniser has filled; buck-boost writes
  arriving before that are ignored, so the host waits a few cycles after reset.
*/
`include "bbsr_cfg.svh"
`default_nettype none
module bbsr_regs
  import bbsr_pkg::*;
#(
  parameter int BLANK_CYC = `BBSR_BLANK_CYC,
  parameter int STEP_BASE_CYC = `BBSR_STEP_BASE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic password_ok,
  input wire logic resistor_default_select,
  input wire logic buck_setpoint_wr,
  input wire logic [5:0] third_buck_code,
  output logic [11:0] third_buck_mv,
  output logic buck_boost_pskip,
  output logic [5:0] buck_boost_code,
  output logic supervision_blank,
  output logic buck_slew_step,
  output logic buck_slew_busy
);
  logic [2:0] strap_sync_q;
  logic [1:0] strap_fill_q;
  logic strap_caught_q;
  logic [7:0] bb_q;
  logic trig_q;
  logic bypass_q;
  logic [2:0] rate_q;
  logic [31:0] blank_cnt_q;
  logic [31:0] blank_load;
  logic blank_q;
  logic [31:0] dwell_q;
  logic [31:0] dwell_len;
  logic [31:0] dwell_load;
  logic step_q;
  bbsr_state_t state_q;
  logic wr_bb;
  logic wr_slew;
  logic start;
  logic [2:0] rate_eff;
  logic step_end;
  logic tb3_upper;
  logic [5:0] tb3_offset;

  // decoded strobes and per-step dwell, all in the one clock domain
  assign wr_bb = reg_wr && (reg_addr == `BBSR_ADDR_BB);
  assign wr_slew = reg_wr && (reg_addr == `BBSR_ADDR_SLEW);
  assign start = (wr_slew && reg_wdata[`BBSR_BIT_TRIG]) || (bypass_q && buck_setpoint_wr);
  // a trigger write that also changes the rate must already dwell at the new rate
  assign rate_eff = wr_slew ? reg_wdata[`BBSR_RATE_MSB:0] : rate_q;
  // dwell doubles per code below 6; shift by (6 - code)
  assign dwell_len = 32'(STEP_BASE_CYC) << (`BBSR_RATE_SLOW_SHIFT - rate_eff);
  assign dwell_load = (rate_eff == `BBSR_RATE_IMM) ? 32'h0 : dwell_len - 32'h1;
  assign step_end = (state_q == BBSR_STEP) && (dwell_q == 32'h0);
  // cut to the counter width on purpose
  assign blank_load = 32'(BLANK_CYC - 1);
  assign tb3_upper = (third_buck_code >= `BBSR_TB3_UPPER);
  // wraps below the upper table; only used while tb3_upper is set
  assign tb3_offset = third_buck_code - `BBSR_TB3_UPPER;

  // strap passes three flops; only the last two are compared
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_sync_q <= 3'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[1:0], resistor_default_select};
    end
  end

  // counts the edges the synchroniser needs to fill after reset release
  // saturates once full, so it costs nothing after start-up
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_fill_q <= 2'h0;
    end else if (strap_fill_q != `BBSR_STRAP_FILL) begin
      strap_fill_q <= strap_fill_q + 2'h1;
    end
  end

  // buck-boost control register; bit 6 never stored so it reads zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bb_q <= `BBSR_BB_RESET;
      strap_caught_q <= 1'b0;
    end else if (!strap_caught_q) begin
      // strap value counts only once the last two synchroniser stages agree
      if (strap_fill_q == `BBSR_STRAP_FILL && strap_sync_q[2] == strap_sync_q[1]) begin
        strap_caught_q <= 1'b1;
        if (strap_sync_q[2]) begin
          bb_q <= `BBSR_BB_ALT_RESET;
        end
      end
    end else if (wr_bb && password_ok) begin
      bb_q <= {reg_wdata[`BBSR_BIT_PSKIP], 1'b0, reg_wdata[`BBSR_CODE_MSB:0]};
    end
  end

  // slew configuration fields; bits 5-3 are never stored so they read zero
  // bypass and rate take effect on the write edge; the engine sees rate_eff meanwhile
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bypass_q <= 1'b0;
      rate_q <= 3'(`BBSR_SLEW_RESET & `BBSR_SLEW_RATE_MASK);
    end else if (wr_slew) begin
      bypass_q <= reg_wdata[`BBSR_BIT_BYPASS];
      rate_q <= reg_wdata[`BBSR_RATE_MSB:0];
    end
  end

  // trigger bit; a host set wins over the self-clear at transition end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trig_q <= 1'b0;
    end else if (wr_slew && reg_wdata[`BBSR_BIT_TRIG]) begin
      trig_q <= 1'b1;
    end else if (step_end && !start) begin
      trig_q <= 1'b0;
    end
  end

  // blanking counter restarts on every buck-boost write attempt, protected or not
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blank_cnt_q <= 32'h0;
    end else if (wr_bb) begin
      blank_cnt_q <= blank_load;
    end else if (blank_cnt_q != 32'h0) begin
      blank_cnt_q <= blank_cnt_q - 32'h1;
    end
  end

  // blanking flag drops the cycle after the counter runs out
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blank_q <= 1'b0;
    end else if (wr_bb) begin
      blank_q <= 1'b1;
    end else if (blank_cnt_q == 32'h0) begin
      blank_q <= 1'b0;
    end
  end

  // stepping engine: one step pulse per dwell; analog side reports arrival by set-point
  // write ending here is a limitation: the end is one dwell after the start
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= BBSR_IDLE;
      dwell_q <= 32'h0;
    end else begin
      unique case (state_q)
        BBSR_IDLE: begin
          if (start) begin
            state_q <= BBSR_STEP;
            dwell_q <= dwell_load;
          end
        end
        BBSR_STEP: begin
          // a start landing on the last dwell cycle chains straight into the next step
          if (dwell_q == 32'h0) begin
            state_q <= start ? BBSR_STEP : BBSR_IDLE;
            dwell_q <= dwell_load;
          end else begin
            dwell_q <= dwell_q - 32'h1;
          end
        end
      endcase
    end
  end

  // one-cycle pulse per voltage step for the first two bucks only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      step_q <= 1'b0;
    end else begin
      step_q <= step_end;
    end
  end

  // read data is registered and holds until the next read; unmapped reads give zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `BBSR_ADDR_BB: reg_rdata <= bb_q;
        `BBSR_ADDR_SLEW: reg_rdata <= {trig_q, bypass_q, 3'h0, rate_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // third buck upper table; lower codes belong to another block and give zero here
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      third_buck_mv <= 12'h000;
    end else if (tb3_upper) begin
      third_buck_mv <= 12'(`BBSR_TB3_BASE_MV + `BBSR_TB3_STEP_MV * tb3_offset);
    end else begin
      third_buck_mv <= 12'h000;
    end
  end

  assign buck_boost_pskip = bb_q[`BBSR_BIT_PSKIP];
  assign buck_boost_code = bb_q[`BBSR_CODE_MSB:0];
  assign supervision_blank = blank_q;
  assign buck_slew_step = step_q;
  assign buck_slew_busy = trig_q;
endmodule // bbsr_regs
`default_nettype wire

// ===== tb/bbsr_checker.sv
/* checker for the bbsr_regs ports.
   assumes a bind onto bbsr_regs built with short blanking and dwell. */
`default_nettype none
module bbsr_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic password_ok,
  input wire logic buck_setpoint_wr,
  input wire logic [5:0] third_buck_code,
  input wire logic [11:0] third_buck_mv,
  input wire logic buck_boost_pskip,
  input wire logic [5:0] buck_boost_code,
  input wire logic supervision_blank,
  input wire logic buck_slew_step,
  input wire logic buck_slew_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic bbw = reg_wr && reg_addr == 8'h19;
  // helper: a step is legal only after a trigger write or a bypassed set-point write
  logic bypass_seen_q;
  logic pending_q;
  wire logic start_seen = (reg_wr && reg_addr == 8'h1A && reg_wdata[7])
    || (bypass_seen_q && buck_setpoint_wr);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bypass_seen_q <= 1'b0;
      pending_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h1A) begin
        bypass_seen_q <= reg_wdata[6];
      end
      if (start_seen) begin
        pending_q <= 1'b1;
      end else if (buck_slew_step) begin
        pending_q <= 1'b0;
      end
    end
  end
  property p_mv;
    third_buck_code >= 6'h24 |=>
      third_buck_mv == 12'(2050 + 50 * ($past(third_buck_code) - 36));
  endproperty
  property p_bbw;
    bbw && password_ok |=> buck_boost_pskip == $past(reg_wdata[7])
      && buck_boost_code == $past(reg_wdata[5:0]);
  endproperty
  property p_prot;
    bbw && !password_ok |=> $stable(buck_boost_code) && $stable(buck_boost_pskip);
  endproperty
  property p_blank;
    bbw |=> supervision_blank [*8];
  endproperty
  property p_trig;
    reg_wr && reg_addr == 8'h1A && reg_wdata[7] |=> buck_slew_busy;
  endproperty
  // slowest rate is 128 cycles here, so 200 leaves margin
  property p_bmax;
    $rose(buck_slew_busy) |-> ##[1:200] !buck_slew_busy;
  endproperty
  property p_step;
    buck_slew_step |-> pending_q;
  endproperty
  property p_rst;
    $rose(resetn) |-> buck_boost_pskip && buck_boost_code == 6'h32 && !supervision_blank;
  endproperty
  a_mv: assert property (p_mv) else $error("third buck mv wrong");
  a_bbw: assert property (p_bbw) else $error("buck-boost write lost");
  a_prot: assert property (p_prot) else $error("protected write took");
  a_blank: assert property (p_blank) else $error("blank missing");
  a_trig: assert property (p_trig) else $error("trigger not set");
  a_bmax: assert property (p_bmax) else $error("trigger never clears");
  a_step: assert property (p_step) else $error("stray step");
  a_rst: assert property (p_rst) else $error("bad reset value");
  c_blank: cover property ($rose(supervision_blank));
  c_step: cover property (buck_slew_step);
  c_prot: cover property (bbw && !password_ok);
  c_bypass: cover property (bypass_seen_q && buck_setpoint_wr);
endmodule // bbsr_checker
bind bbsr_regs bbsr_checker bbsr_checker_inst (.*);
`default_nettype wire

// ===== tb/bbsr_host.sv
/* host model driving the register port of bbsr_regs.
   assumes mclk from the bench; signals move 1 ns after mclk rises. */
`default_nettype none
module bbsr_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output var logic reg_wr = 1'b0,
  output var logic reg_rd = 1'b0,
  output var logic [7:0] reg_addr = 8'h00,
  output var logic [7:0] reg_wdata = 8'h00,
  output var logic password_ok = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic pw(input logic v);
    password_ok = v;
  endtask
  // callers keep buck-boost codes below 35h and write only with it disabled
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk) #1;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
endmodule // bbsr_host
`default_nettype wire

// ===== tb/tb.sv
/* self-checking bench for bbsr_regs.
   assumes 100 MHz mclk, blanking 20 cycles, dwell base 2 cycles. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, resetn, wr, rd, pwok, setp, pskip, blank, step, busy, strap;
  logic [7:0] addr, wdat, rdat, d;
  logic [5:0] tb3 = 6'h00, code;
  logic [11:0] mv;
  int n_fail = 0, total_checks = 0, n, t[8];
  bbsr_regs #(.BLANK_CYC(20), .STEP_BASE_CYC(2)) bbsr_regs_inst (.mclk(mclk), .resetn(resetn),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdat), .reg_rdata(rdat),
    .password_ok(pwok), .resistor_default_select(strap), .buck_setpoint_wr(setp),
    .third_buck_code(tb3), .third_buck_mv(mv), .buck_boost_pskip(pskip),
    .buck_boost_code(code), .supervision_blank(blank), .buck_slew_step(step),
    .buck_slew_busy(busy));
  bbsr_host bbsr_host_inst (.mclk(mclk), .reg_rdata(rdat), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(addr), .reg_wdata(wdat), .password_ok(pwok));
  task automatic report_and_stop;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bbsr_host_inst.rd(a, d);
    chk(12'(d), 12'(e));
  endtask
  // counts cycles while blank (s=1) or busy (s=0) stays high; bounded
  task automatic wt(input bit s, output int c);
    c = 0;
    while ((s ? blank : busy) === 1'b1 && c < 300) begin
      @(posedge mclk) #1;
      c++;
    end
    if (c >= 300) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic pulse;
    @(posedge mclk) #1;
    setp = 1'b1;
    @(posedge mclk) #1;
    setp = 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    resetn = 1'b0;
    setp = 1'b0;
    strap = 1'b1;
    repeat (2) @(posedge mclk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge mclk);
    rdc(8'h19, 8'hB2);
    rdc(8'h1A, 8'h06);
    rdc(8'h1B, 8'h00);
    bbsr_host_inst.wr(8'h19, 8'h74);
    wt(1, n);
    chk(12'(n), 12'd20);
    rdc(8'h19, 8'hB2);
    bbsr_host_inst.pw(1'b1);
    bbsr_host_inst.wr(8'h19, 8'h74);
    rdc(8'h19, 8'h34);
    chk(12'({pskip, code}), 12'h034);
    bbsr_host_inst.wr(8'h1A, 8'hFE);
    wt(0, n);
    rdc(8'h1A, 8'h46);
    bbsr_host_inst.wr(8'h1A, 8'h47);
    pulse();
    chk(12'(busy), 12'd0);
    @(posedge mclk) #1;
    chk(12'(step), 12'd1);
    wt(0, n);
    bbsr_host_inst.wr(8'h1A, 8'h07);
    pulse();
    chk(12'(busy), 12'd0);
    @(posedge mclk) #1;
    chk(12'(step), 12'd0);
    for (int i = 0; i < 8; i++) begin
      bbsr_host_inst.wr(8'h1A, 8'h80 | 8'(i));
      wt(0, t[i]);
    end
    // absolute latency is design-chosen, so only dwell differences are compared
    for (int i = 0; i < 6; i++) begin
      chk(12'(t[i] - t[6]), 12'((2 << (6 - i)) - 2));
    end
    chk(12'(t[7] <= t[6]), 12'd1);
    for (int i = 35; i < 64; i++) begin
      @(posedge mclk) #1 tb3 = 6'(i);
      @(posedge mclk) #1;
      chk(mv, (i < 36) ? 12'd0 : 12'(2050 + 50 * (i - 36)));
    end
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
